/* File: logic/rbt_regs.svh */
// Constants for the registered bus transceiver
`ifndef RBT_REGS_SVH
`define RBT_REGS_SVH
`define RBT_BUS_W 16
`define RBT_BYTE_W 8
`define RBT_HALVES 2
`define RBT_STORE_RST 16'h0000
`endif

/* File: logic/rbt_pkg.sv */
// Types for the registered bus transceiver
`include "rbt_regs.svh"
package rbt_pkg;
  typedef logic [`RBT_BYTE_W-1:0] rbt_byte_t;
  typedef enum logic [1:0] {RBT_ISOLATE, RBT_A_TO_B, RBT_B_TO_A, RBT_BOTH} rbt_mode_t;
endpackage

/* File: logic/rbt_half_if.sv */
// Per-half control bundle between the top and the byte slice
`timescale 1ns/1ps
`default_nettype none
interface rbt_half_if;
  logic a_to_b_drive_enable;
  logic b_to_a_drive_enable_low;
  logic a_cap_rise;
  logic b_cap_rise;
  logic b_output_source_select;
  logic a_output_source_select;
  modport top (output a_to_b_drive_enable, b_to_a_drive_enable_low, a_cap_rise, b_cap_rise,
    b_output_source_select, a_output_source_select);
  modport slice (input a_to_b_drive_enable, b_to_a_drive_enable_low, a_cap_rise, b_cap_rise,
    b_output_source_select, a_output_source_select);
endinterface
`default_nettype wire

/* File: logic/rbt_slice.sv */
// One byte half: storage registers and output selection
`timescale 1ns/1ps
`default_nettype none
`include "rbt_regs.svh"
module rbt_slice
  import rbt_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  rbt_half_if.slice ctl,
  input wire rbt_byte_t a_in,
  input wire rbt_byte_t b_in,
  output var rbt_byte_t a_out_ff,
  output var rbt_byte_t b_out_ff,
  output var logic a_oe_ff,
  output var logic b_oe_ff
);
  rbt_byte_t a_port_storage_register_ff;
  rbt_byte_t b_port_storage_register_ff;
  wire rbt_byte_t nxt_b_out;
  wire rbt_byte_t nxt_a_out;
  wire logic nxt_b_oe;
  wire logic nxt_a_oe;

  // Enable decode and source selection
  assign nxt_b_oe = ctl.a_to_b_drive_enable;
  assign nxt_a_oe = ~ctl.b_to_a_drive_enable_low;
  assign nxt_b_out = ctl.b_output_source_select ? a_port_storage_register_ff : a_in;
  assign nxt_a_out = ctl.a_output_source_select ? b_port_storage_register_ff : b_in;

  // Storage loads on capture rise only, never gated by enables or selects
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      a_port_storage_register_ff <= rbt_byte_t'(`RBT_STORE_RST);
      b_port_storage_register_ff <= rbt_byte_t'(`RBT_STORE_RST);
    end
    else
    begin
      if (ctl.a_cap_rise)
        a_port_storage_register_ff <= a_in;
      if (ctl.b_cap_rise)
        b_port_storage_register_ff <= b_in;
    end
  end

  // Registered port drive; both may drive for loop-back or exchange
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      a_out_ff <= '0;
      b_out_ff <= '0;
      a_oe_ff <= 1'b0;
      b_oe_ff <= 1'b0;
    end
    else
    begin
      a_out_ff <= nxt_a_out;
      b_out_ff <= nxt_b_out;
      a_oe_ff <= nxt_a_oe;
      b_oe_ff <= nxt_b_oe;
    end
  end

  // Storage holds without a capture rise
  property p_a_hold;
    @(posedge core_clk) disable iff (!rst_b)
    !ctl.a_cap_rise |=> $stable(a_port_storage_register_ff);
  endproperty
  a_a_hold: assert property (p_a_hold) else $error("A store changed without capture");

  property p_b_load;
    @(posedge core_clk) disable iff (!rst_b)
    ctl.b_cap_rise |=> b_port_storage_register_ff == $past(b_in);
  endproperty
  a_b_load: assert property (p_b_load) else $error("B store missed capture");

  property p_b_stored;
    @(posedge core_clk) disable iff (!rst_b)
    ctl.a_to_b_drive_enable && ctl.b_output_source_select && !ctl.a_cap_rise
      |=> b_oe_ff && b_out_ff == a_port_storage_register_ff;
  endproperty
  a_b_stored: assert property (p_b_stored) else $error("B not showing A store");

  property p_a_live;
    @(posedge core_clk) disable iff (!rst_b)
    !ctl.b_to_a_drive_enable_low && !ctl.a_output_source_select |=> a_oe_ff && a_out_ff == $past(b_in);
  endproperty
  a_a_live: assert property (p_a_live) else $error("A not following B");

  property p_b_live;
    @(posedge core_clk) disable iff (!rst_b)
    ctl.a_to_b_drive_enable && !ctl.b_output_source_select |=> b_out_ff == $past(a_in);
  endproperty
  a_b_live: assert property (p_b_live) else $error("B not following A");

  property p_a_stored;
    @(posedge core_clk) disable iff (!rst_b)
    !ctl.b_to_a_drive_enable_low && ctl.a_output_source_select && !ctl.b_cap_rise
      |=> a_out_ff == b_port_storage_register_ff;
  endproperty
  a_a_stored: assert property (p_a_stored) else $error("A not showing B store");

  property p_iso;
    @(posedge core_clk) disable iff (!rst_b)
    !ctl.a_to_b_drive_enable && ctl.b_to_a_drive_enable_low |=> !a_oe_ff && !b_oe_ff;
  endproperty
  a_iso: assert property (p_iso) else $error("Port driven in isolation");

  property p_a_load;
    @(posedge core_clk) disable iff (!rst_b)
    ctl.a_cap_rise |=> a_port_storage_register_ff == $past(a_in);
  endproperty
  a_a_load: assert property (p_a_load) else $error("A store missed capture");
endmodule // rbt_slice
`default_nettype wire

/* File: logic/rbt_top.sv */
// Top of the 16-bit registered bus transceiver
//
// Summary of operation
// - Path splits into two byte halves, each with own controls.
// - Each register loads from its port on its own capture rise.
// - Without a capture rise, register contents hold.
// - Capture is never gated by enables or selects.
// - A-to-B enable high drives B; low B-to-A enable drives A.
// - Isolation floats both ports; registers still load.
// - B drives live A when its select is low.
// - B drives A storage when its select is high.
// - A drives live B when its select is low.
// - A drives B storage when its select is high.
// - Capture during live transfer loads without disturbing transfer.
// - Input data may go to either or both registers.
// - Both ports live driving reinforce their own levels.
// - Both driving with stored selects exchange register contents.
`timescale 1ns/1ps
`default_nettype none
`include "rbt_regs.svh"
module rbt_top
  import rbt_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [`RBT_HALVES-1:0] a_to_b_drive_enable,
  input wire logic [`RBT_HALVES-1:0] b_to_a_drive_enable_low,
  input wire logic [`RBT_HALVES-1:0] a_port_capture_clock,
  input wire logic [`RBT_HALVES-1:0] b_port_capture_clock,
  input wire logic [`RBT_HALVES-1:0] b_output_source_select,
  input wire logic [`RBT_HALVES-1:0] a_output_source_select,
  input wire logic [`RBT_BUS_W-1:0] port_a_lines_i,
  output var logic [`RBT_BUS_W-1:0] port_a_lines_o,
  output var logic [`RBT_BUS_W-1:0] port_a_lines_oe,
  input wire logic [`RBT_BUS_W-1:0] port_b_lines_i,
  output var logic [`RBT_BUS_W-1:0] port_b_lines_o,
  output var logic [`RBT_BUS_W-1:0] port_b_lines_oe
);
  // ************************************************
  // Pin synchronisers: three stages, change once stages 2 and 3 agree
  // ************************************************
  localparam int CW = 6 * `RBT_HALVES;
  logic [CW-1:0] c_s1_ff, c_s2_ff, c_s3_ff, c_q_ff, c_q_d_ff;
  logic [`RBT_BUS_W-1:0] a_s1_ff, a_s2_ff, a_s3_ff, a_q_ff;
  logic [`RBT_BUS_W-1:0] b_s1_ff, b_s2_ff, b_s3_ff, b_q_ff;
  wire logic [CW-1:0] c_raw;
  wire logic [CW-1:0] nxt_c_q;
  wire logic [`RBT_BUS_W-1:0] nxt_a_q;
  wire logic [`RBT_BUS_W-1:0] nxt_b_q;

  // Filter helper: accept the new level only when stages agree
  function automatic logic [`RBT_BUS_W-1:0] agree(input logic [`RBT_BUS_W-1:0] s2,
    input logic [`RBT_BUS_W-1:0] s3, input logic [`RBT_BUS_W-1:0] q);
    agree = (s2 & s3) | (q & (s2 | s3));
  endfunction

  assign c_raw = {a_to_b_drive_enable, b_to_a_drive_enable_low, a_port_capture_clock,
    b_port_capture_clock, b_output_source_select, a_output_source_select};
  assign nxt_c_q = (c_s2_ff & c_s3_ff) | (c_q_ff & (c_s2_ff | c_s3_ff));
  assign nxt_a_q = agree(a_s2_ff, a_s3_ff, a_q_ff);
  assign nxt_b_q = agree(b_s2_ff, b_s3_ff, b_q_ff);

  // Synchroniser stages for controls and data
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      c_s1_ff <= '0;
      c_s2_ff <= '0;
      c_s3_ff <= '0;
      c_q_ff <= '0;
      c_q_d_ff <= '0;
      a_s1_ff <= '0;
      a_s2_ff <= '0;
      a_s3_ff <= '0;
      a_q_ff <= '0;
      b_s1_ff <= '0;
      b_s2_ff <= '0;
      b_s3_ff <= '0;
      b_q_ff <= '0;
    end
    else
    begin
      c_s1_ff <= c_raw;
      c_s2_ff <= c_s1_ff;
      c_s3_ff <= c_s2_ff;
      c_q_ff <= nxt_c_q;
      c_q_d_ff <= c_q_ff;
      a_s1_ff <= port_a_lines_i;
      a_s2_ff <= a_s1_ff;
      a_s3_ff <= a_s2_ff;
      a_q_ff <= nxt_a_q;
      b_s1_ff <= port_b_lines_i;
      b_s2_ff <= b_s1_ff;
      b_s3_ff <= b_s2_ff;
      b_q_ff <= nxt_b_q;
    end
  end

  // ************************************************
  // Byte halves
  // ************************************************
  localparam int H = `RBT_HALVES;
  wire logic [H-1:0] ab_en = c_q_ff[6*H-1 -: H];
  wire logic [H-1:0] ba_en_low = c_q_ff[5*H-1 -: H];
  wire logic [H-1:0] cap_a = c_q_ff[4*H-1 -: H];
  wire logic [H-1:0] cap_a_d = c_q_d_ff[4*H-1 -: H];
  wire logic [H-1:0] cap_b = c_q_ff[3*H-1 -: H];
  wire logic [H-1:0] cap_b_d = c_q_d_ff[3*H-1 -: H];
  wire logic [H-1:0] sel_b = c_q_ff[2*H-1 -: H];
  wire logic [H-1:0] sel_a = c_q_ff[H-1:0];

  logic [H-1:0] a_oe_half;
  logic [H-1:0] b_oe_half;

  // Each half gets its own controls and rising-edge detection
  for (genvar g = 0; g < H; g++)
  begin : g_half
    rbt_half_if hif();
    localparam int LO = g * `RBT_BYTE_W;
    assign hif.a_to_b_drive_enable = ab_en[g];
    assign hif.b_to_a_drive_enable_low = ba_en_low[g];
    assign hif.a_cap_rise = cap_a[g] & ~cap_a_d[g];
    assign hif.b_cap_rise = cap_b[g] & ~cap_b_d[g];
    assign hif.b_output_source_select = sel_b[g];
    assign hif.a_output_source_select = sel_a[g];
    rbt_slice u_slice (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .ctl(hif),
      .a_in(a_q_ff[LO +: `RBT_BYTE_W]),
      .b_in(b_q_ff[LO +: `RBT_BYTE_W]),
      .a_out_ff(port_a_lines_o[LO +: `RBT_BYTE_W]),
      .b_out_ff(port_b_lines_o[LO +: `RBT_BYTE_W]),
      .a_oe_ff(a_oe_half[g]),
      .b_oe_ff(b_oe_half[g])
    );
  end

  // Spread per-half enables over every line; registered for clean outputs
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      port_a_lines_oe <= '0;
      port_b_lines_oe <= '0;
    end
    else
    begin
      port_a_lines_oe <= {{`RBT_BYTE_W{a_oe_half[1]}}, {`RBT_BYTE_W{a_oe_half[0]}}};
      port_b_lines_oe <= {{`RBT_BYTE_W{b_oe_half[1]}}, {`RBT_BYTE_W{b_oe_half[0]}}};
    end
  end

  // Halves are independent: enabling one B half leaves the other floating
  property p_half_indep;
    @(posedge core_clk) disable iff (!rst_b)
    (ab_en == 2'b01) ##1 (ab_en == 2'b01) |=> port_b_lines_oe == 16'h00ff;
  endproperty
  a_half_indep: assert property (p_half_indep) else $error("Half enables not independent");
endmodule // rbt_top
`default_nettype wire

/* File: sim/rbt_bus_model.sv */
// Far-side bus model: one parallel bus that shares its lines with the transceiver
`timescale 1ns/1ps
`default_nettype none
module rbt_bus_model
(
  input wire logic core_clk,
  input wire logic [15:0] dut_o,
  input wire logic [15:0] dut_oe,
  input wire logic [15:0] val,
  input wire logic drv,
  output wire logic [15:0] line
);
  logic [15:0] float_ff;
  // Undriven lines toggle every cycle so no stale level passes for data
  always_ff @(posedge core_clk)
  begin
    float_ff <= (float_ff === 16'h5555) ? 16'haaaa : 16'h5555;
  end
  // Wire level: transceiver where it drives, else this bus or the float pattern
  assign line = (dut_oe & dut_o) | (~dut_oe & (drv ? val : float_ff));
endmodule // rbt_bus_model
`default_nettype wire

/* File: sim/registered_bus_transceiver_test.sv */
// Self-checking bench for the registered bus transceiver
`timescale 1ns/1ps
`default_nettype none
module registered_bus_transceiver_test;
  // ************
  // Bench signals
  // ************
  logic core_clk;
  logic rst_b;
  logic [1:0] ab, bal, ca, cb, sab, sba;
  logic [15:0] a_val, b_val, a_in, b_in, a_o, a_oe, b_o, b_oe;
  logic a_drv, b_drv;
  int err_count, check_count;
  rbt_top dut (.core_clk(core_clk), .rst_b(rst_b), .a_to_b_drive_enable(ab),
    .b_to_a_drive_enable_low(bal), .a_port_capture_clock(ca), .b_port_capture_clock(cb),
    .b_output_source_select(sab), .a_output_source_select(sba), .port_a_lines_i(a_in),
    .port_a_lines_o(a_o), .port_a_lines_oe(a_oe), .port_b_lines_i(b_in),
    .port_b_lines_o(b_o), .port_b_lines_oe(b_oe));
  rbt_bus_model bus_a (.core_clk(core_clk), .dut_o(a_o), .dut_oe(a_oe), .val(a_val),
    .drv(a_drv), .line(a_in));
  rbt_bus_model bus_b (.core_clk(core_clk), .dut_o(b_o), .dut_oe(b_oe), .val(b_val),
    .drv(b_drv), .line(b_in));
  // Clock at 4 ns period
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic test_done;
    if (err_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Settle time covers the six-edge path from pin to output enable
  task automatic mode(input logic [1:0] m_ab, m_bal, m_sab, m_sba);
    ab <= m_ab;
    bal <= m_bal;
    sab <= m_sab;
    sba <= m_sba;
    cyc(8);
  endtask
  task automatic bus(input logic ad, input logic [15:0] av, input logic bd,
    input logic [15:0] bv);
    a_drv <= ad;
    a_val <= av;
    b_drv <= bd;
    b_val <= bv;
    cyc(8);
  endtask
  task automatic cap(input logic [1:0] c_a, input logic [1:0] c_b);
    ca <= c_a;
    cb <= c_b;
    cyc(8);
  endtask
  // ************
  // Scenarios
  // ************
  task automatic t_isolate;
    bus(1'b1, 16'h1234, 1'b1, 16'habcd);
    mode(2'b00, 2'b11, 2'b00, 2'b00);
    check("iso a_oe", 16'h0000, a_oe);
    check("iso b_oe", 16'h0000, b_oe);
    cap(2'b11, 2'b11);
    cap(2'b00, 2'b00);
  endtask
  task automatic t_a_to_b;
    bus(1'b1, 16'h55aa, 1'b0, 16'h0000);
    mode(2'b11, 2'b11, 2'b00, 2'b00);
    check("ab b_oe", 16'hffff, b_oe);
    check("ab a_oe", 16'h0000, a_oe);
    check("ab live", 16'h55aa, b_o);
    bus(1'b1, 16'h0f0f, 1'b0, 16'h0000);
    check("ab follow", 16'h0f0f, b_o);
    mode(2'b11, 2'b11, 2'b11, 2'b00);
    check("ab stored", 16'h1234, b_o);
    cap(2'b11, 2'b00);
    check("ab load", 16'h0f0f, b_o);
    bus(1'b1, 16'h3c3c, 1'b0, 16'h0000);
    check("ab hold high", 16'h0f0f, b_o);
    cap(2'b00, 2'b00);
    bus(1'b1, 16'h6969, 1'b0, 16'h0000);
    check("ab hold low", 16'h0f0f, b_o);
  endtask
  task automatic t_b_to_a;
    mode(2'b00, 2'b00, 2'b00, 2'b00);
    bus(1'b0, 16'h0000, 1'b1, 16'hc3c3);
    check("ba a_oe", 16'hffff, a_oe);
    check("ba b_oe", 16'h0000, b_oe);
    check("ba live", 16'hc3c3, a_o);
    mode(2'b00, 2'b00, 2'b00, 2'b11);
    check("ba stored", 16'habcd, a_o);
    cap(2'b00, 2'b11);
    check("ba load", 16'hc3c3, a_o);
    cap(2'b00, 2'b00);
  endtask
  task automatic t_halves;
    mode(2'b01, 2'b11, 2'b00, 2'b00);
    bus(1'b1, 16'h8421, 1'b0, 16'h0000);
    check("lo b_oe", 16'h00ff, b_oe);
    check("lo b_o", 16'h0021, b_o & 16'h00ff);
    mode(2'b10, 2'b11, 2'b00, 2'b00);
    check("hi b_oe", 16'hff00, b_oe);
    bus(1'b0, 16'h0000, 1'b1, 16'h8421);
    mode(2'b00, 2'b10, 2'b00, 2'b00);
    check("lo a_oe", 16'h00ff, a_oe);
  endtask
  task automatic t_exchange(input logic [15:0] ea, input logic [15:0] eb);
    bus(1'b0, 16'h0000, 1'b0, 16'h0000);
    mode(2'b11, 2'b00, 2'b11, 2'b11);
    check("xchg a_o", ea, a_o);
    check("xchg b_o", eb, b_o);
  endtask
  task automatic t_store_both;
    mode(2'b11, 2'b11, 2'b00, 2'b00);
    bus(1'b1, 16'h7e81, 1'b0, 16'h0000);
    cap(2'b11, 2'b11);
    cap(2'b00, 2'b00);
    t_exchange(16'h7e81, 16'h7e81);
  endtask
  task automatic t_loop;
    mode(2'b11, 2'b11, 2'b00, 2'b00);
    bus(1'b1, 16'h2db4, 1'b0, 16'h0000);
    mode(2'b11, 2'b00, 2'b00, 2'b00);
    bus(1'b0, 16'h0000, 1'b0, 16'h0000);
    check("loop a_o", 16'h2db4, a_o);
    check("loop b_o", 16'h2db4, b_o);
  endtask
  // Watchdog against a hung run
  initial
  begin
    cyc(30000);
    err_count++;
    test_done;
  end
  // Main sequence
  initial
  begin
    rst_b = 1'b0;
    {ab, bal, ca, cb, sab, sba} = 12'h300;
    {a_val, b_val, a_drv, b_drv} = 34'h0;
    err_count = 0;
    check_count = 0;
    cyc(4);
    rst_b <= 1'b1;
    cyc(1);
    t_isolate;
    t_a_to_b;
    t_b_to_a;
    t_halves;
    t_exchange(16'hc3c3, 16'h0f0f);
    t_store_both;
    t_loop;
    test_done;
  end
endmodule // registered_bus_transceiver_test
`default_nettype wire
